/* File: rtl/cmp_ctl.sv */
// comparator digital control: registers, input steering, sync latch, edge irq
`timescale 1ns/100ps
module cmp_ctl
  import cmp_ctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire reg_req_t bus_req,
  output logic [DATA_W-1:0] rdata,
  input wire logic cmp_raw,
  input wire logic tmr_clk_presc,
  input wire logic amp_enable,
  output analog_ctl_t analog_ctl,
  output logic gate_src,
  output logic irq
);
  logic [DATA_W-1:0] ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d;
  logic [3:0] psel_q, psel_d, nsel_q, nsel_d;
  logic [1:0] stat_q, stat_d, mask_q, mask_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic cmp_s1_q, cmp_s2_q, tck_s1_q, tck_s2_q, tck_s3_q, amp_s1_q, amp_s2_q;
  logic sync_lat_q, sync_lat_d, out_prev_q, gate_q, gate_d, irq_q, irq_d;
  analog_ctl_t actl_q, actl_d;
  logic out_now, rise_p, fall_p, tck_fall, flag_set, flag_clr;

  // two-flop synchronisers for the analog result and amp enable, three flops for the timer clock
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      tck_s1_q <= 1'b0;
      tck_s2_q <= 1'b0;
      tck_s3_q <= 1'b0;
      amp_s1_q <= 1'b0;
      amp_s2_q <= 1'b0;
    end else begin
      cmp_s1_q <= cmp_raw;
      cmp_s2_q <= cmp_s1_q;
      tck_s1_q <= tmr_clk_presc;
      tck_s2_q <= tck_s1_q;
      tck_s3_q <= tck_s2_q;
      amp_s1_q <= amp_enable;
      amp_s2_q <= amp_s1_q;
    end
  end

  // polarity-adjusted output; off zeroes the result before invert, so power toggles with a high result are changes
  assign out_now = (cmp_s2_q & ctrl_a_q[CA_POWER]) ^ ctrl_a_q[CA_INVERT];
  assign rise_p = out_now & ~out_prev_q;
  assign fall_p = ~out_now & out_prev_q;
  // falling edge of prescaled timer clock, seen on system clock
  assign tck_fall = tck_s3_q & ~tck_s2_q;
  assign flag_set = (rise_p & ctrl_b_q[CB_RISE]) | (fall_p & ctrl_b_q[CB_FALL]);
  assign flag_clr = bus_req.rd && bus_req.addr == OFS_IRQ_STAT;

  // register writes, status flags, read mux, sync latch and analog steering
  always_comb begin
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    psel_d = psel_q;
    nsel_d = nsel_q;
    mask_d = mask_q;
    rdata_d = RST_ZERO;
    if (bus_req.wr) begin
      case (bus_req.addr)
        OFS_CTRL_A: ctrl_a_d = bus_req.wdata;
        OFS_CTRL_B: ctrl_b_d = bus_req.wdata;
        OFS_POS_MUX: psel_d = bus_req.wdata[3:0];
        OFS_NEG_MUX: nsel_d = bus_req.wdata[3:0];
        OFS_IRQ_MASK: mask_d = bus_req.wdata[1:0];
        default: ;
      endcase
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_CTRL_A: rdata_d = ctrl_a_q;
        OFS_CTRL_B: rdata_d = ctrl_b_q;
        OFS_POS_MUX: rdata_d = {4'h0, psel_q};
        OFS_NEG_MUX: rdata_d = {4'h0, nsel_q};
        OFS_IRQ_STAT: rdata_d = {6'h00, stat_q};
        OFS_IRQ_MASK: rdata_d = {6'h00, mask_q};
        OFS_STATUS: rdata_d = {6'h00, sync_lat_q, out_now};
        default: rdata_d = RST_ZERO;
      endcase
    end
    // bit0 comparator flag, bit1 any polarity-adjusted output change; set wins over clear
    stat_d = flag_clr ? 2'h0 : stat_q;
    stat_d[0] = stat_d[0] | flag_set;
    stat_d[1] = stat_d[1] | rise_p | fall_p;
    irq_d = |(stat_d & mask_d);
    sync_lat_d = tck_fall ? out_now : sync_lat_q;
    gate_d = ctrl_a_q[CA_ALIGN] ? sync_lat_q : out_now;
    actl_d = '0;
    actl_d.deadband_on = ctrl_a_q[CA_DEADBAND] & ctrl_a_q[CA_POWER];
    if (ctrl_a_q[CA_POWER]) begin
      case (psel_q)
        PSEL_PIN: actl_d.pos_sw = 5'h01;
        PSEL_RAMP: actl_d.pos_sw = 5'h02;
        PSEL_DAC: actl_d.pos_sw = 5'h04;
        PSEL_FREF: actl_d.pos_sw = 5'h08;
        PSEL_GND: actl_d.pos_sw = 5'h10;
        default: actl_d.pos_sw = 5'h00;
      endcase
      case (nsel_q)
        NSEL_PIN: begin
          actl_d.neg_sw = 3'h1;
          actl_d.neg_from_amp = amp_s2_q;
        end
        NSEL_FREF: actl_d.neg_sw = 3'h2;
        NSEL_GND: actl_d.neg_sw = 3'h4;
        default: actl_d.neg_sw = 3'h0;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_a_q <= RST_ZERO;
      ctrl_b_q <= RST_ZERO;
      psel_q <= 4'h0;
      nsel_q <= 4'h0;
      stat_q <= 2'h0;
      mask_q <= 2'h0;
      rdata_q <= RST_ZERO;
      irq_q <= 1'b0;
      sync_lat_q <= 1'b0;
      gate_q <= 1'b0;
      out_prev_q <= 1'b0;
      actl_q <= '0;
    end else begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      psel_q <= psel_d;
      nsel_q <= nsel_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      sync_lat_q <= sync_lat_d;
      gate_q <= gate_d;
      out_prev_q <= out_now;
      actl_q <= actl_d;
    end
  end

  assign rdata = rdata_q;
  assign analog_ctl = actl_q;
  assign gate_src = gate_q;
  assign irq = irq_q;

  // checks
  a_flag_sets: assert property (@(posedge clk_sys) disable iff (!nrst)
    flag_set |=> stat_q[0]) else $error("flag not set after enabled edge");
  a_set_beats_clr: assert property (@(posedge clk_sys) disable iff (!nrst)
    (flag_set && flag_clr) |=> stat_q[0]) else $error("edge lost on clear");
  a_rise_pulse: assert property (@(posedge clk_sys) disable iff (!nrst)
    rise_p |=> !rise_p) else $error("rise pulse longer than one cycle");
  a_edge_cause: assert property (@(posedge clk_sys) disable iff (!nrst)
    (rise_p || fall_p) |-> out_now != $past(out_now)) else $error("edge w/o change");
  a_off_no_sw: assert property (@(posedge clk_sys) disable iff (!nrst)
    !ctrl_a_q[CA_POWER] |=> actl_q.pos_sw == 5'h00 && actl_q.neg_sw == 3'h0)
    else $error("inputs connected while off");
  a_deadband_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
    !ctrl_a_q[CA_DEADBAND] |=> !actl_q.deadband_on) else $error("deadband on");
  a_unsync_path: assert property (@(posedge clk_sys) disable iff (!nrst)
    !ctrl_a_q[CA_ALIGN] |=> gate_q == $past(out_now)) else $error("gate not direct");
  a_latch_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !tck_fall |=> $stable(sync_lat_q)) else $error("latch moved off clock edge");
  a_invert_change: assert property (@(posedge clk_sys) disable iff (!nrst)
    $changed(ctrl_a_q[CA_INVERT]) && $stable(ctrl_a_q[CA_POWER]) && $stable(cmp_s2_q)
    |-> rise_p || fall_p) else $error("invert toggle not an edge");
  a_irq_level: assert property (@(posedge clk_sys) disable iff (!nrst)
    (stat_q[0] && mask_q[0]) |-> irq) else $error("irq low with pending flag");
  c_rise_irq: cover property (@(posedge clk_sys) disable iff (!nrst) rise_p && flag_set);
  c_fall_irq: cover property (@(posedge clk_sys) disable iff (!nrst) fall_p && flag_set);
  c_set_clr: cover property (@(posedge clk_sys) disable iff (!nrst) flag_set && flag_clr);
  c_sync_gate: cover property (@(posedge clk_sys) disable iff (!nrst)
    ctrl_a_q[CA_ALIGN] && tck_fall);
endmodule : cmp_ctl

/* File: rtl/cmp_ctl_pkg.sv */
// constants, field layouts and carriers for the comparator control block
// Notes on behaviour
// - deadband (hysteresis) drive is on only while its enable bit is set
// - polarity-adjusted output is offered as a gate source for the timer
// - timer-aligned latch is used only when the align bit is set
// - latch captures on the falling edge of the timer source clock
// - with a prescaler, the prescaled timer clock drives the latch
// - each comparator has one rising and one falling edge detector
// - flag sets on rise with rise enable, or fall with fall enable
// - software clears the flag; a same-cycle enabled edge keeps it set
// - toggling invert while off still counts as an output change; toggling power counts only with a high result
// - positive select picks pin, ramp, converter, fixed reference or ground
// - power bit at zero disconnects every input selection
// - negative select picks pin, fixed reference or analog ground
// - shared inverting pin with amplifier enabled feeds amplifier output
package cmp_ctl_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL_A = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_POS_MUX = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_NEG_MUX = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h6;
  // ctrl_a bit positions
  localparam int CA_POWER = 7;
  localparam int CA_INVERT = 4;
  localparam int CA_DEADBAND = 1;
  localparam int CA_ALIGN = 0;
  // ctrl_b bit positions
  localparam int CB_RISE = 1;
  localparam int CB_FALL = 0;
  // positive select codes
  localparam logic [3:0] PSEL_PIN = 4'h0;
  localparam logic [3:0] PSEL_RAMP = 4'h1;
  localparam logic [3:0] PSEL_DAC = 4'h2;
  localparam logic [3:0] PSEL_FREF = 4'h3;
  localparam logic [3:0] PSEL_GND = 4'h4;
  // negative select codes
  localparam logic [3:0] NSEL_PIN = 4'h0;
  localparam logic [3:0] NSEL_FREF = 4'h1;
  localparam logic [3:0] NSEL_GND = 4'h2;
  localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;
  // one-hot analog switch controls, bit order as the select codes
  typedef struct packed {
    logic [4:0] pos_sw;
    logic [2:0] neg_sw;
    logic neg_from_amp;
    logic deadband_on;
  } analog_ctl_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : cmp_ctl_pkg

/* File: test/cmp_ctl_tb.sv */
// self-checking bench for the comparator control block
`timescale 1ns/100ps
module cmp_ctl_tb;
  import cmp_ctl_pkg::*;
  `define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  reg_req_t bus_req = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] d;
  logic level = 1'b0;
  logic amp_enable = 1'b0;
  logic cmp_raw, tmr_clk_presc, gate_src, irq;
  analog_ctl_t analog_ctl;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  always #10 clk_sys = ~clk_sys;
  cmp_ctl cmp_ctl_inst (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .rdata(rdata),
    .cmp_raw(cmp_raw), .tmr_clk_presc(tmr_clk_presc), .amp_enable(amp_enable),
    .analog_ctl(analog_ctl), .gate_src(gate_src), .irq(irq));
  cmp_far_model cmp_far_model_inst (.level(level), .cmp_raw(cmp_raw),
    .tmr_clk_presc(tmr_clk_presc));
  // one-cycle write strobe
  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask : reg_write
  // one-cycle read strobe, data taken in the following cycle
  task automatic reg_read(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_read
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    settle(2);
    `CHK(analog_ctl, 10'h000)
    reg_write(OFS_CTRL_A, 8'h82);
    for (int i = 0; i < 5; i++) begin
      reg_write(OFS_POS_MUX, 8'(i));
      settle(3);
      `CHK(analog_ctl.pos_sw, 5'(1 << i))
    end
    for (int i = 0; i < 3; i++) begin
      reg_write(OFS_NEG_MUX, 8'(i));
      settle(3);
      `CHK(analog_ctl.neg_sw, 3'(1 << i))
    end
    `CHK(analog_ctl.deadband_on, 1'b1)
    reg_write(OFS_NEG_MUX, 8'h00);
    amp_enable <= 1'b1;
    settle(4);
    `CHK(analog_ctl.neg_from_amp, 1'b1)
    reg_write(OFS_CTRL_A, 8'h00);
    settle(3);
    `CHK({analog_ctl.pos_sw, analog_ctl.neg_sw, analog_ctl.deadband_on}, 9'h000)
    // interrupt on rising edge only
    reg_read(OFS_IRQ_STAT);
    reg_write(OFS_IRQ_MASK, 8'h01);
    reg_write(OFS_CTRL_B, 8'h02);
    reg_write(OFS_CTRL_A, 8'h80);
    level <= 1'b1;
    settle(8);
    `CHK(irq, 1'b1)
    `CHK(gate_src, 1'b1)
    reg_read(OFS_IRQ_STAT);
    `CHK(d, 8'h03)
    reg_read(OFS_IRQ_STAT);
    `CHK(d, 8'h00)
    `CHK(irq, 1'b0)
    level <= 1'b0;
    settle(8);
    reg_read(OFS_IRQ_STAT);
    `CHK(d, 8'h02)
    // invert toggled with power off still counts
    reg_write(OFS_CTRL_B, 8'h03);
    reg_write(OFS_CTRL_A, 8'h10);
    settle(6);
    reg_read(OFS_IRQ_STAT);
    `CHK(d, 8'h03)
    // timer-aligned gate source
    reg_write(OFS_CTRL_A, 8'h81);
    // let one timer fall load a known low into the latch first
    @(negedge tmr_clk_presc);
    settle(8);
    @(posedge tmr_clk_presc);
    settle(2);
    level <= 1'b1;
    settle(20);
    `CHK(gate_src, 1'b0)
    @(negedge tmr_clk_presc);
    settle(8);
    `CHK(gate_src, 1'b1)
    reg_read(OFS_STATUS);
    `CHK(d, 8'h03)
    reg_write(4'hf, 8'hff);
    reg_read(4'hf);
    `CHK(d, 8'h00)
    give_verdict();
  end
endmodule : cmp_ctl_tb

/* File: test/cmp_far_model.sv */
// far side: analog comparator result and prescaled timer clock
`timescale 1ns/100ps
module cmp_far_model (
  input wire logic level,
  output logic cmp_raw,
  output logic tmr_clk_presc
);
  // start values
  initial begin
    cmp_raw = 1'b0;
    tmr_clk_presc = 1'b0;
  end
  // input pins taken as analog inputs with drivers off
  // analog result settles a little after the commanded level
  always @(level) cmp_raw <= #7 level;
  // prescaled timer clock, free running, unrelated to the system clock
  always #1010 tmr_clk_presc = ~tmr_clk_presc;
endmodule : cmp_far_model
